// ---- verilog/iee_pkg.sv ----
// constants and types shared by the interrupt entry/exit sequencer
// Operation
// - accepting an interrupt clears global enable
// - global enable set in handler allows nesting
// - return from handler sets global enable
// - vectoring clears the served flag
// - writing one clears a flag
// - flag latches while its enable is off
// - pending flags served by priority once enabled
// - level requests count only while present
// - one program instruction runs after return
// - status register never saved or restored
// - clear-enable instruction blocks interrupts at once
// - instruction after set-enable runs first
// - entry takes four cycles, pushes return address
// - vector jump takes three cycles
// - multi-cycle instruction finishes before entry
// - wake from sleep adds four cycles
// - return takes four cycles, pops two bytes
// - lowest vector number wins, request zero first
// - needs individual and global enable set
// - entry push lowers stack pointer by two
package iee_pkg;
  localparam int unsigned PC_W      = 16;
  localparam int unsigned SP_W      = 16;
  localparam logic [15:0] SP_RST    = 16'h02ff;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] POP_HI_OFS = 16'h0001;
  localparam logic [15:0] POP_LO_OFS = 16'h0002;
  localparam logic [15:0] VEC_BASE  = 16'h0000;
  localparam logic [15:0] VEC_STRIDE = 16'h0002;
  localparam logic [2:0]  ENTRY_CYC = 3'h4;
  localparam logic [2:0]  WAKE_CYC  = 3'h4;
  localparam logic [2:0]  JUMP_CYC  = 3'h3;
  localparam logic [2:0]  RET_CYC   = 3'h4;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAKE,
    ST_ENTRY,
    ST_JUMP,
    ST_RETURN
  } iee_state_t;

  // one byte-wide stack memory request
  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } iee_stk_t;

  // source n sits n+1 slots above the reset vector
  function automatic logic [15:0] iee_vec_addr(input logic [15:0] idx);
    iee_vec_addr = VEC_BASE + VEC_STRIDE * (idx + 16'h0001);
  endfunction
endpackage

// ---- verilog/iee_prio_pick.sv ----
// fixed priority picker: lowest source index wins
`timescale 1ns/100ps
`default_nettype none
module iee_prio_pick #(
  parameter int unsigned N  = 8,
  parameter int unsigned IW = 3
) (
  input  wire logic [N-1:0]  i_req,
  output logic               o_any,
  output logic [IW-1:0]      o_idx
);
  // scan downward so the lowest set index is written last
  always_comb begin
    o_any = |i_req;
    o_idx = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (i_req[k]) begin
        o_idx = IW'(k);
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/iee_core.sv ----
// interrupt entry and exit sequencer for the cpu core
`timescale 1ns/100ps
`default_nettype none
module iee_core #(
  parameter int unsigned      NSRC      = 8,
  parameter int unsigned      IW        = 3,
  parameter logic [NSRC-1:0]  FLAG_TYPE = {NSRC{1'b1}}
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_ce,
  input  wire logic [NSRC-1:0]         i_src_cond,
  input  wire logic [NSRC-1:0]         i_src_en,
  input  wire logic                    i_flag_clr_wr,
  input  wire logic [NSRC-1:0]         i_flag_clr_data,
  input  wire logic                    i_insn_done,
  input  wire logic                    i_op_sei,
  input  wire logic                    i_op_cli,
  input  wire logic                    i_op_return_from_handler_op,
  input  wire logic                    i_gie_wr,
  input  wire logic                    i_gie_wdata,
  input  wire logic                    i_sp_wr,
  input  wire logic [15:0]             i_sp_wdata,
  input  wire logic                    i_sleeping,
  input  wire logic                    i_wake_ok,
  input  wire logic [15:0]             i_ret_pc,
  input  wire logic [7:0]              i_stack_rdata,
  output logic                         o_gie,
  output logic [NSRC-1:0]              o_flags,
  output logic [15:0]                  o_sp,
  output iee_pkg::iee_stk_t            o_stk,
  output logic                         o_pc_load,
  output logic [15:0]                  o_pc_val,
  output logic                         o_ack,
  output logic [IW-1:0]                o_ack_idx,
  output logic                         o_busy,
  output logic                         o_in_vec
);

  typedef struct packed {
    iee_pkg::iee_state_t st;
    logic [2:0]          cnt;
    logic                gie;
    logic [15:0]         sp;
    logic [NSRC-1:0]     flags;
    logic [7:0]          pc_hi;
    logic [IW-1:0]       idx;
    iee_pkg::iee_stk_t   stk;
    logic                pc_load;
    logic [15:0]         pc_val;
    logic                ack;
    logic                busy;
    logic                in_vec;
  } iee_core_st_t;

  iee_core_st_t state_r;
  iee_core_st_t state_nxt;
  logic [NSRC-1:0] req;
  logic            req_any;
  logic [IW-1:0]   req_idx;
  logic            boundary;
  logic            accept;
  logic            wake_accept;

  // latched flags need their enable; level sources pass through unlatched but also need it
  always_comb begin
    req = (state_r.flags & i_src_en)
        | (i_src_cond & ~FLAG_TYPE & i_src_en);
  end

  iee_prio_pick #(
    .N  (NSRC),
    .IW (IW)
  ) u_pick (
    .i_req (req),
    .o_any (req_any),
    .o_idx (req_idx)
  );

  // entry only between instructions; sei/cli/return_from_handler_op boundaries never qualify
  always_comb begin
    boundary = i_insn_done & ~i_op_sei & ~i_op_cli & ~i_op_return_from_handler_op;
    accept   = (state_r.st == iee_pkg::ST_RUN) & boundary & ~i_sleeping
             & state_r.gie & req_any;
    wake_accept = (state_r.st == iee_pkg::ST_RUN) & i_sleeping & i_wake_ok
                & ~i_op_cli & state_r.gie & req_any;
  end

  // next state of the whole sequencer
  always_comb begin
    state_nxt = state_r;
    state_nxt.stk.we  = 1'b0;
    state_nxt.stk.re  = 1'b0;
    state_nxt.pc_load = 1'b0;
    state_nxt.ack     = 1'b0;

    // software clear first, event set last so a simultaneous event wins
    if (i_flag_clr_wr) begin
      state_nxt.flags = state_nxt.flags & ~i_flag_clr_data;
    end

    // only the enable bit is touched; other status bits belong to software
    if (state_r.st == iee_pkg::ST_RUN) begin
      if (i_gie_wr) begin
        state_nxt.gie = i_gie_wdata;
      end
      if (i_op_sei & i_insn_done) begin
        state_nxt.gie = 1'b1;
      end
      if (i_op_cli) begin
        state_nxt.gie = 1'b0;
      end
      if (i_sp_wr) begin
        state_nxt.sp = i_sp_wdata;
      end
    end

    case (state_r.st)
      iee_pkg::ST_RUN: begin
        if (i_op_return_from_handler_op & i_insn_done) begin
          // first pop: high byte sits just above the stack pointer
          state_nxt.st       = iee_pkg::ST_RETURN;
          state_nxt.cnt      = 3'h0;
          state_nxt.busy     = 1'b1;
          state_nxt.stk.re   = 1'b1;
          state_nxt.stk.addr = state_r.sp + iee_pkg::POP_HI_OFS;
        end else if (wake_accept) begin
          state_nxt.st   = iee_pkg::ST_WAKE;
          state_nxt.cnt  = 3'h0;
          state_nxt.busy = 1'b1;
          state_nxt.gie  = 1'b0;
          state_nxt.idx  = req_idx;
        end else if (accept) begin
          // push low byte of the resume address now
          state_nxt.st        = iee_pkg::ST_ENTRY;
          state_nxt.cnt       = 3'h0;
          state_nxt.busy      = 1'b1;
          state_nxt.gie       = 1'b0;
          state_nxt.idx       = req_idx;
          state_nxt.stk.we    = 1'b1;
          state_nxt.stk.addr  = state_r.sp;
          state_nxt.stk.wdata = i_ret_pc[7:0];
          state_nxt.sp        = state_r.sp - iee_pkg::BYTE_STEP;
          state_nxt.pc_hi     = i_ret_pc[15:8];
        end
      end

      iee_pkg::ST_WAKE: begin
        // extra wake-up cycles, then the normal entry push
        state_nxt.cnt = state_r.cnt + 3'h1;
        if (state_r.cnt == iee_pkg::WAKE_CYC - 3'h1) begin
          state_nxt.st        = iee_pkg::ST_ENTRY;
          state_nxt.cnt       = 3'h0;
          state_nxt.stk.we    = 1'b1;
          state_nxt.stk.addr  = state_r.sp;
          state_nxt.stk.wdata = i_ret_pc[7:0];
          state_nxt.sp        = state_r.sp - iee_pkg::BYTE_STEP;
          state_nxt.pc_hi     = i_ret_pc[15:8];
        end
      end

      iee_pkg::ST_ENTRY: begin
        state_nxt.cnt = state_r.cnt + 3'h1;
        if (state_r.cnt == 3'h0) begin
          state_nxt.stk.we    = 1'b1;
          state_nxt.stk.addr  = state_r.sp;
          state_nxt.stk.wdata = state_r.pc_hi;
          state_nxt.sp        = state_r.sp - iee_pkg::BYTE_STEP;
        end
        if (state_r.cnt == iee_pkg::ENTRY_CYC - 3'h2) begin
          state_nxt.st      = iee_pkg::ST_JUMP;
          state_nxt.cnt     = 3'h0;
          state_nxt.busy    = 1'b0;
          state_nxt.in_vec  = 1'b1;
          state_nxt.pc_load = 1'b1;
          state_nxt.pc_val  = iee_pkg::iee_vec_addr(16'(state_r.idx));
          state_nxt.ack     = 1'b1;
          // hardware clear of the served flag; set still wins below
          state_nxt.flags[state_r.idx] = 1'b0;
        end
      end

      iee_pkg::ST_JUMP: begin
        // core runs the vector's jump; nothing may be accepted meanwhile
        state_nxt.cnt = state_r.cnt + 3'h1;
        if (state_r.cnt == iee_pkg::JUMP_CYC - 3'h1) begin
          state_nxt.st     = iee_pkg::ST_RUN;
          state_nxt.in_vec = 1'b0;
        end
      end

      iee_pkg::ST_RETURN: begin
        state_nxt.cnt = state_r.cnt + 3'h1;
        if (state_r.cnt == 3'h0) begin
          state_nxt.stk.re   = 1'b1;
          state_nxt.stk.addr = state_r.sp + iee_pkg::POP_LO_OFS;
        end
        if (state_r.cnt == 3'h1) begin
          state_nxt.pc_hi = i_stack_rdata;
        end
        // back to run: next boundary is the resumed instruction's own
        if (state_r.cnt == iee_pkg::RET_CYC - 3'h2) begin
          state_nxt.st      = iee_pkg::ST_RUN;
          state_nxt.busy    = 1'b0;
          state_nxt.pc_load = 1'b1;
          state_nxt.pc_val  = {state_r.pc_hi, i_stack_rdata};
          state_nxt.sp      = state_r.sp + iee_pkg::POP_LO_OFS;
          state_nxt.gie     = 1'b1;
        end
      end

      default: begin
        state_nxt.st = iee_pkg::ST_RUN;
      end
    endcase

    // events are never lost to a clear in the same cycle
    state_nxt.flags = state_nxt.flags | (i_src_cond & FLAG_TYPE);
  end

  // single state register; clock enable freezes everything
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r       <= '0;
      state_r.st    <= iee_pkg::ST_RUN;
      state_r.sp    <= iee_pkg::SP_RST;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state flops
  assign o_gie     = state_r.gie;
  assign o_flags   = state_r.flags;
  assign o_sp      = state_r.sp;
  assign o_stk     = state_r.stk;
  assign o_pc_load = state_r.pc_load;
  assign o_pc_val  = state_r.pc_val;
  assign o_ack     = state_r.ack;
  assign o_ack_idx = state_r.idx;
  assign o_busy    = state_r.busy;
  assign o_in_vec  = state_r.in_vec;

  // checks run on enabled clock edges only, matching the frozen state
  default clocking cb @(posedge i_clk iff i_ce);
  endclocking
  default disable iff (i_sys_rst);

  gie_clear_a: assert property (accept |=> !o_gie)
    else $error("global enable not cleared on entry");

  entry_len_a: assert property (accept |=> !o_pc_load [*3] ##1 (o_pc_load && o_ack))
    else $error("entry did not vector after four cycles");

  entry_sp_a: assert property (accept |-> ##2 (o_sp == $past(o_sp, 2) - 16'h0002))
    else $error("entry did not lower stack pointer by two");

  entry_push_a: assert property (accept |=> o_stk.we && o_stk.wdata == $past(i_ret_pc[7:0])
    ##1 o_stk.we && o_stk.wdata == $past(i_ret_pc[15:8], 2))
    else $error("resume address not pushed low then high");

  ret_len_a: assert property ((state_r.st == iee_pkg::ST_RUN && i_op_return_from_handler_op && i_insn_done)
    |=> !o_pc_load [*3] ##1 (o_pc_load && o_gie))
    else $error("return did not finish in four cycles with enable set");

  ret_sp_a: assert property ((state_r.st == iee_pkg::ST_RUN && i_op_return_from_handler_op && i_insn_done)
    |-> ##4 (o_sp == $past(o_sp, 4) + 16'h0002))
    else $error("return did not raise stack pointer by two");

  cli_block_a: assert property (i_op_cli && state_r.st == iee_pkg::ST_RUN
    |=> state_r.st != iee_pkg::ST_ENTRY && state_r.st != iee_pkg::ST_WAKE && !o_gie)
    else $error("interrupt taken alongside clear-enable");

  sei_first_a: assert property (i_op_sei && i_insn_done |=> state_r.st != iee_pkg::ST_ENTRY)
    else $error("interrupt taken before instruction after set-enable");

  boundary_a: assert property ((state_r.st == iee_pkg::ST_RUN && state_nxt.st == iee_pkg::ST_ENTRY)
    |-> i_insn_done && state_r.gie && (|req))
    else $error("entry began off an instruction boundary");

  flag_set_a: assert property ((|(i_src_cond & FLAG_TYPE))
    |=> (o_flags & $past(i_src_cond & FLAG_TYPE)) == $past(i_src_cond & FLAG_TYPE))
    else $error("flag event lost");

  w1c_a: assert property (i_flag_clr_wr && !(|i_src_cond)
    |=> (o_flags & $past(i_flag_clr_data)) == '0)
    else $error("write-one did not clear flag");

  hw_clear_a: assert property (o_ack && !$past(i_src_cond[o_ack_idx]) |-> !o_flags[o_ack_idx])
    else $error("served flag not cleared on vectoring");

  wake_len_a: assert property (wake_accept |=> o_busy && !o_stk.we [*4] ##1 o_stk.we)
    else $error("wake entry lacks four extra cycles");

  jump_len_a: assert property ($rose(o_in_vec) |-> o_in_vec [*3] ##1 !o_in_vec)
    else $error("vector jump window not three cycles");

  pick_low_a: assert property (accept |-> req[req_idx] && ((req & ~({NSRC{1'b1}} << req_idx)) == '0))
    else $error("lower-numbered request passed over");

endmodule
`default_nettype wire

// ---- bench/iee_src_model.sv ----
// model of the on-chip peripherals that raise interrupt conditions
`timescale 1ns/100ps
`default_nettype none
module iee_src_model #(
  parameter logic [7:0] FLAG_TYPE = 8'hff
) (
  input  wire logic [7:0] i_evt,
  input  wire logic [7:0] i_lvl,
  output logic [7:0]      o_cond
);
  // flag sources give one-cycle strobes, level sources hold while present
  assign o_cond = (i_evt & FLAG_TYPE) | (i_lvl & ~FLAG_TYPE);
endmodule
`default_nettype wire

// ---- bench/cpu_interrupt_entry_exit_tb.sv ----
// self-checking bench for the interrupt entry and exit sequencer
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_entry_exit_tb;
  localparam logic [7:0] FT = 8'h7f;
  logic              i_clk = 1'b0;
  logic              i_sys_rst = 1'b1;
  logic [7:0]        evt = 8'h00, lvl = 8'h00, cond, en = 8'h00, clr_d = 8'h00, rdata = 8'h00;
  logic              clr_wr = 1'b0, done = 1'b0, sei = 1'b0, cli = 1'b0, return_from_handler_op = 1'b0;
  logic              gie_wr = 1'b0, sp_wr = 1'b0, sleeping = 1'b0, wake_ok = 1'b0, ce = 1'b1, gie_wd = 1'b0;
  logic [15:0]       sp_wd = 16'h0000, ret_pc = 16'h0000;
  logic              o_gie, o_pc_load, o_ack, o_busy, o_in_vec;
  logic [7:0]        o_flags;
  logic [15:0]       o_sp, o_pc_val;
  logic [2:0]        o_ack_idx;
  iee_pkg::iee_stk_t o_stk;
  int                num_errors = 0;
  int                n_compared = 0;
  int                seed = 84442;
  int                sp_m = 0;
  logic [7:0]        flg_m = 8'h00;
  logic [23:0]       q[$];

  always #10 i_clk = ~i_clk;

  iee_src_model #(.FLAG_TYPE(FT)) iee_src_model_inst (.i_evt(evt), .i_lvl(lvl), .o_cond(cond));

  iee_core #(.NSRC(8), .IW(3), .FLAG_TYPE(FT)) iee_core_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_src_cond(cond), .i_src_en(en),
    .i_flag_clr_wr(clr_wr), .i_flag_clr_data(clr_d), .i_insn_done(done), .i_op_sei(sei),
    .i_op_cli(cli), .i_op_return_from_handler_op(return_from_handler_op), .i_gie_wr(gie_wr), .i_gie_wdata(gie_wd), .i_sp_wr(sp_wr),
    .i_sp_wdata(sp_wd), .i_sleeping(sleeping), .i_wake_ok(wake_ok), .i_ret_pc(ret_pc),
    .i_stack_rdata(rdata), .o_gie(o_gie), .o_flags(o_flags), .o_sp(o_sp), .o_stk(o_stk),
    .o_pc_load(o_pc_load), .o_pc_val(o_pc_val), .o_ack(o_ack), .o_ack_idx(o_ack_idx),
    .o_busy(o_busy), .o_in_vec(o_in_vec));

  task automatic tick();
    @(negedge i_clk);
  endtask

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // lowest pending enabled source, -1 when none
  function automatic int pick();
    logic [7:0] r;
    r = (flg_m | (lvl & ~FT)) & en;
    for (int k = 0; k < 8; k++) if (r[k]) return k;
    return -1;
  endfunction

  task automatic fire(input logic [7:0] m);
    evt = m;
    tick();
    evt = 8'h00;
    flg_m = flg_m | (m & FT);
    cmp(o_flags, flg_m);
  endtask

  // one entry from a boundary (or wake) to the end of the vector jump
  task automatic enter(input int lat);
    int          idx, n;
    logic [15:0] pc;
    idx = pick();
    pc = 16'($random(seed));
    ret_pc = pc;
    done = !sleeping;
    n = 0;
    q.delete();
    do begin
      tick();
      done = 1'b0;
      sleeping = 1'b0;
      n++;
      if (o_stk.we) q.push_back({o_stk.addr, o_stk.wdata});
    end while (!o_ack && n < 12);
    cmp(n, lat);
    if (!o_ack) conclude();
    cmp(q.size(), 2);
    cmp(q[0], {sp_m[15:0], pc[7:0]});
    cmp(q[1], {sp_m[15:0] - 16'h0001, pc[15:8]});
    sp_m -= 2;
    cmp(o_sp, sp_m);
    cmp(o_ack_idx, idx);
    cmp(o_pc_val, 2 * (idx + 1));
    cmp(o_gie, 1'b0);
    if (idx < 7) flg_m[idx] = 1'b0;
    cmp(o_flags, flg_m);
    for (int k = 0; k < 3; k++) begin
      cmp(o_in_vec, 1'b1);
      tick();
    end
    cmp(o_in_vec, 1'b0);
  endtask

  // return from handler, stack ram answers one cycle after each read
  task automatic leave();
    logic [15:0] pc;
    pc = 16'($random(seed));
    return_from_handler_op = 1'b1;
    done = 1'b1;
    tick();
    return_from_handler_op = 1'b0;
    done = 1'b0;
    cmp({o_stk.re, o_stk.addr}, {1'b1, sp_m[15:0] + 16'h0001});
    tick();
    rdata = pc[15:8];
    cmp({o_stk.re, o_stk.addr}, {1'b1, sp_m[15:0] + 16'h0002});
    tick();
    rdata = pc[7:0];
    tick();
    rdata = ~pc[7:0];
    cmp({o_pc_load, o_pc_val}, {1'b1, pc});
    sp_m += 2;
    cmp(o_sp, sp_m);
    cmp(o_gie, 1'b1);
  endtask

  task automatic boundary(input logic b_sei, input logic b_cli);
    sei = b_sei;
    cli = b_cli;
    done = 1'b1;
    tick();
    {sei, cli, done} = 3'b000;
    cmp(o_busy, 1'b0);
  endtask

  task automatic set_gie(input logic v);
    gie_wd = v;
    gie_wr = 1'b1;
    tick();
    gie_wr = 1'b0;
  endtask

  // main sequence: reset held two cycles, then one test per block
  initial begin
    repeat (2) tick();
    i_sys_rst = 1'b0;
    tick();
    cmp({o_sp, o_gie, o_flags}, {iee_pkg::SP_RST, 1'b0, 8'h00});
    sp_wd = 16'h0200 + {8'h00, 8'($random(seed))};
    sp_wr = 1'b1;
    // clock enable low: the write must wait for an enabled edge
    ce = 1'b0;
    tick();
    cmp(o_sp, iee_pkg::SP_RST);
    ce = 1'b1;
    tick();
    sp_wr = 1'b0;
    sp_m = sp_wd;
    cmp(o_sp, sp_m);
    $display("test reset and stack pointer done");
    fire(8'h28);
    clr_wr = 1'b1;
    clr_d = 8'h20;
    tick();
    clr_wr = 1'b0;
    flg_m[5] = 1'b0;
    cmp(o_flags, flg_m);
    $display("test flag latch and clear done");
    fire(8'h24 | (8'($random(seed)) & 8'h7f));
    en = 8'hff;
    boundary(1'b0, 1'b0);
    set_gie(1'b1);
    repeat (3) tick();
    cmp(o_busy, 1'b0);
    for (int k = 0; k < 8 && pick() >= 0; k++) begin
      enter(4);
      leave();
    end
    $display("test pending priority order done");
    fire(8'h06);
    enter(4);
    set_gie(1'b1);
    enter(4);
    leave();
    leave();
    $display("test nesting done");
    // flag already pending with enable on, so only the clear can stop entry
    fire(8'h10);
    boundary(1'b0, 1'b1);
    repeat (3) tick();
    cmp({o_busy, o_gie}, 2'b00);
    boundary(1'b1, 1'b0);
    enter(4);
    leave();
    // set-enable while already enabled: its own boundary must not accept
    fire(8'h02);
    boundary(1'b1, 1'b0);
    enter(4);
    leave();
    $display("test clear and set enable done");
    en = 8'h7f;
    lvl = 8'h80;
    tick();
    lvl = 8'h00;
    en = 8'hff;
    boundary(1'b0, 1'b0);
    cmp(o_flags[7], 1'b0);
    lvl = 8'h80;
    enter(4);
    lvl = 8'h00;
    leave();
    $display("test level source done");
    fire(8'h08);
    sleeping = 1'b1;
    repeat (2) tick();
    cmp(o_busy, 1'b0);
    wake_ok = 1'b1;
    enter(8);
    wake_ok = 1'b0;
    leave();
    $display("test wake from sleep done");
    // software write of zero keeps a pending flag waiting
    set_gie(1'b0);
    cmp(o_gie, 1'b0);
    fire(8'h01);
    boundary(1'b0, 1'b0);
    $display("test enable write done");
    conclude();
  end
endmodule
`default_nettype wire
